// ===== hw/zone_pkg.sv
// shared constants, types and records of the obstacle zone status logic
// assumes a 100 MHz device clock; all timing counts derive from it
package zone_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_KHZ = 100000; // device clock rate in kHz (100 MHz)
	localparam int INIT_TIME_MS = 15000; // start-up phase before detection
	localparam int INIT_CYCLES = INIT_TIME_MS * CLK_KHZ; // 1.5e9 fits in int
	localparam int BLINK_FAST_MS = 200; // blink period, inner level or colour variant
	localparam int BLINK_MID_MS = 800; // blink period, middle level
	localparam int BLINK_SLOW_MS = 2000; // blink period, outer level
	// half periods, since the lamp toggles twice per period
	localparam int BLINK_FAST_HALF = BLINK_FAST_MS * CLK_KHZ / 2;
	localparam int BLINK_MID_HALF = BLINK_MID_MS * CLK_KHZ / 2;
	localparam int BLINK_SLOW_HALF = BLINK_SLOW_MS * CLK_KHZ / 2;

	// ****************************************
	// widths and codes
	// ****************************************
	localparam int GROUPS = 16; // working area groups
	localparam int LEVELS = 3; // outer, middle, inner
	localparam int SW_W = 4; // switch inputs
	localparam int CNT_W = 32; // width of long counters
	localparam int PAY_W = 32; // record payload width
	localparam logic [7:0] NORMAL_STATUS_CODE = 8'h00; // running without fault
	localparam logic [7:0] INIT_STATUS_CODE = 8'h01; // still starting up
	localparam int LVL_OUTER = 0; // bit positions in level vectors
	localparam int LVL_MIDDLE = 1;
	localparam int LVL_INNER = 2;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic {ST_INIT, ST_DETECT} run_state_t;
	typedef enum logic [1:0] {REC_POINT, REC_ZONE, REC_STATUS} rec_kind_t;
	typedef enum logic [1:0] {COLOR_GREEN, COLOR_YELLOW, COLOR_RED} led_color_t;
	typedef struct packed {
		rec_kind_t kind; // what the payload carries
		logic [PAY_W-1:0] payload; // point word, zone result or status code
	} tx_rec_t;

endpackage

// ===== hw/blink_gen.sv
// square-wave lamp driver with a programmable half period
// assumes half_cycles_in is at least 2 and changes only with the level shown
`timescale 1ns/10ps
`default_nettype none

module blink_gen (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic run_in,
	input wire logic [zone_pkg::CNT_W-1:0] half_cycles_in,
	output logic blink_out
);

	// ****************************************
	// state
	// ****************************************
	logic [zone_pkg::CNT_W-1:0] cnt_ff; // cycles in the current half period
	logic [zone_pkg::CNT_W-1:0] half_prev_ff; // half period seen last cycle
	logic blink_ff; // lamp level
	wire restart = half_cycles_in != half_prev_ff; // pattern changed
	wire at_end = cnt_ff == half_cycles_in - 32'h1;

	// steady lit when idle; a new pattern restarts lit so no short flash appears
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_ff <= 32'h0;
			half_prev_ff <= 32'h0;
			blink_ff <= 1'b1;
		end else begin
			half_prev_ff <= half_cycles_in;
			if (!run_in || restart) begin
				cnt_ff <= 32'h0;
				blink_ff <= 1'b1;
			end else if (at_end) begin
				cnt_ff <= 32'h0;
				blink_ff <= ~blink_ff;
			end else begin
				cnt_ff <= cnt_ff + 32'h1;
			end
		end
	end

	assign blink_out = blink_ff;

	// ****************************************
	// checks
	// ****************************************
	chk_blink_toggle_point: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$changed(blink_ff) && $past(run_in) && $past(half_cycles_in) == $past(half_prev_ff)
		|-> $past(cnt_ff) == $past(half_cycles_in) - 32'h1)
		else $error("lamp toggled before its half period ended");
	chk_blink_idle_lit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!run_in |=> blink_ff)
		else $error("lamp not lit while idle");

endmodule

`default_nettype wire

// ===== hw/obstacle_zone_status_logic.sv
// status, streaming and indicator logic of a scanning obstacle sensor
// assumes zone hits, scan points and upload enable come from logic on CLK_IN,
// and the four switch inputs come straight from pins
//
// How it works
// - wait about 15 s, then enter detection
// - keep evaluating zone hits while detecting
// - stream points, zone results, status unasked
// - report normal status code when detecting without fault
// - upload disable stops all monitoring records
// - four synchronised switches select area group
// - results use only the selected group's outlines
// - three outputs show outer, middle, inner hits
// - power lamp always lit; run lamp steady if clear
// - colour variant: level colour, 200 ms blink
// - single lamp: 2000/800/200 ms by level
`timescale 1ns/10ps
`default_nettype none

module obstacle_zone_status_logic #(
	parameter int INIT_CYCLES = zone_pkg::INIT_CYCLES, // shorten in simulation
	parameter int FAST_HALF = zone_pkg::BLINK_FAST_HALF,
	parameter int MID_HALF = zone_pkg::BLINK_MID_HALF,
	parameter int SLOW_HALF = zone_pkg::BLINK_SLOW_HALF
) (
	input wire logic CLK_IN,
	input wire logic RESET_N_IN,
	input wire logic [zone_pkg::SW_W-1:0] SWITCH_IN,
	input wire logic [zone_pkg::GROUPS*zone_pkg::LEVELS-1:0] ZONE_HIT_IN,
	input wire logic ZONE_VALID_IN,
	input wire logic [zone_pkg::PAY_W-1:0] POINT_IN,
	input wire logic POINT_VALID_IN,
	output logic POINT_READY_OUT,
	input wire logic UPLOAD_EN_IN,
	input wire logic FAULT_IN,
	input wire logic [7:0] FAULT_CODE_IN,
	input wire logic MULTICOLOR_IN,
	output var zone_pkg::tx_rec_t TX_REC_OUT,
	output logic TX_VALID_OUT,
	input wire logic TX_READY_IN,
	output logic DETECT_OUT,
	output logic [zone_pkg::SW_W-1:0] GROUP_OUT,
	output logic [zone_pkg::LEVELS-1:0] LEVEL_OUT,
	output logic [7:0] STATUS_CODE_OUT,
	output logic POWER_LED_OUT,
	output logic RUN_LED_OUT,
	output var zone_pkg::led_color_t RUN_COLOR_OUT
);

	// ****************************************
	// start-up phase
	// ****************************************
	zone_pkg::run_state_t state_ff; // init or detecting
	zone_pkg::run_state_t nxt_state;
	logic [zone_pkg::CNT_W-1:0] init_cnt_ff; // cycles spent starting up
	wire init_done = init_cnt_ff == INIT_CYCLES - 1;
	wire detect = state_ff == zone_pkg::ST_DETECT;

	// leave init exactly once; there is no way back short of reset
	always_comb begin
		case (state_ff)
			zone_pkg::ST_INIT: nxt_state = init_done ? zone_pkg::ST_DETECT : zone_pkg::ST_INIT;
			zone_pkg::ST_DETECT: nxt_state = zone_pkg::ST_DETECT;
			default: nxt_state = zone_pkg::ST_INIT;
		endcase
	end

	// the counter freezes once detection starts to save toggling power
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state_ff <= zone_pkg::ST_INIT;
			init_cnt_ff <= 32'h0;
		end else begin
			state_ff <= nxt_state;
			if (!detect) init_cnt_ff <= init_cnt_ff + 32'h1;
		end
	end

	// ****************************************
	// switch synchroniser and group select
	// ****************************************
	logic [zone_pkg::SW_W-1:0] sw_s1_ff; // metastable stage, read only by s2
	logic [zone_pkg::SW_W-1:0] sw_s2_ff;
	logic [zone_pkg::SW_W-1:0] sw_s3_ff;
	logic [zone_pkg::SW_W-1:0] group_ff; // active area group
	wire sw_settled = sw_s2_ff == sw_s3_ff; // two stages agree

	// a group change is taken only once two samples agree, filtering edges
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			sw_s1_ff <= 4'h0;
			sw_s2_ff <= 4'h0;
			sw_s3_ff <= 4'h0;
			group_ff <= 4'h0;
		end else begin
			sw_s1_ff <= SWITCH_IN;
			sw_s2_ff <= sw_s1_ff;
			sw_s3_ff <= sw_s2_ff;
			if (sw_settled) group_ff <= sw_s3_ff;
		end
	end

	// ****************************************
	// zone result of the selected group
	// ****************************************
	logic [zone_pkg::LEVELS-1:0] grp_hits [zone_pkg::GROUPS]; // per group slice
	for (genvar g = 0; g < zone_pkg::GROUPS; g++) begin : g_slice
		assign grp_hits[g] = ZONE_HIT_IN[g*zone_pkg::LEVELS +: zone_pkg::LEVELS];
	end
	wire [zone_pkg::LEVELS-1:0] sel_hits = grp_hits[group_ff];
	wire take_zone = detect && ZONE_VALID_IN;
	logic [zone_pkg::LEVELS-1:0] level_ff; // outer, middle, inner hit

	// results outside detection are ignored; levels read clear during init
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			level_ff <= 3'h0;
		end else if (take_zone) begin
			level_ff <= sel_hits;
		end
	end

	// ****************************************
	// status code
	// ****************************************
	logic [7:0] status_ff;
	wire [7:0] nxt_status = !detect ? zone_pkg::INIT_STATUS_CODE :
		FAULT_IN ? FAULT_CODE_IN : zone_pkg::NORMAL_STATUS_CODE;

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) status_ff <= zone_pkg::INIT_STATUS_CODE;
		else status_ff <= nxt_status;
	end

	// ****************************************
	// monitoring stream
	// ****************************************
	logic point_hold_ff; // one scan point waiting
	logic [zone_pkg::PAY_W-1:0] point_ff;
	logic point_ready_ff;
	logic zone_pend_ff; // zone record waiting
	logic [zone_pkg::PAY_W-1:0] zone_word_ff;
	logic status_pend_ff; // status record follows each zone record
	logic tx_valid_ff;
	zone_pkg::tx_rec_t tx_rec_ff;
	wire streaming = detect && UPLOAD_EN_IN;
	wire tx_free = !tx_valid_ff || TX_READY_IN;
	wire load = tx_free && streaming;
	// zone results outrank points so the host never sees a stale level
	wire load_zone = load && zone_pend_ff;
	wire load_status = load && !zone_pend_ff && status_pend_ff;
	wire load_point = load && !zone_pend_ff && !status_pend_ff && point_hold_ff;
	wire point_take = POINT_VALID_IN && point_ready_ff;
	wire [zone_pkg::PAY_W-1:0] zone_word = {21'h0, group_ff, 4'h0, sel_hits};
	logic nxt_point_hold;

	// points arriving while upload is off are taken and dropped, so the
	// ranging side never stalls on a host that stopped listening
	always_comb begin
		nxt_point_hold = point_hold_ff;
		if (load_point || !streaming) nxt_point_hold = 1'b0;
		if (point_take && streaming) nxt_point_hold = 1'b1;
	end

	// pending flags: a new set wins over a same-cycle clear
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			point_hold_ff <= 1'b0;
			point_ff <= 32'h0;
			point_ready_ff <= 1'b0;
			zone_pend_ff <= 1'b0;
			zone_word_ff <= 32'h0;
			status_pend_ff <= 1'b0;
		end else begin
			point_hold_ff <= nxt_point_hold;
			point_ready_ff <= !nxt_point_hold;
			if (point_take) point_ff <= POINT_IN;
			if (take_zone) zone_word_ff <= zone_word;
			if (take_zone && streaming) zone_pend_ff <= 1'b1;
			else if (load_zone || !streaming) zone_pend_ff <= 1'b0;
			if (load_zone) status_pend_ff <= 1'b1;
			else if (load_status || !streaming) status_pend_ff <= 1'b0;
		end
	end

	// a record already offered stays until taken, keeping valid/ready legal
	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			tx_valid_ff <= 1'b0;
			tx_rec_ff <= '0;
		end else if (tx_free) begin
			tx_valid_ff <= load_zone || load_status || load_point;
			if (load_zone) tx_rec_ff <= '{zone_pkg::REC_ZONE, zone_word_ff};
			else if (load_status) tx_rec_ff <= '{zone_pkg::REC_STATUS, {24'h0, status_ff}};
			else if (load_point) tx_rec_ff <= '{zone_pkg::REC_POINT, point_ff};
		end
	end

	// ****************************************
	// indicators
	// ****************************************
	wire obstacle = |level_ff;
	// innermost triggered level decides the pattern; the colour variant always takes the fast one
	wire [zone_pkg::CNT_W-1:0] half_sel =
		(level_ff[zone_pkg::LVL_INNER] || MULTICOLOR_IN) ? FAST_HALF :
		level_ff[zone_pkg::LVL_MIDDLE] ? MID_HALF : SLOW_HALF;
	wire zone_pkg::led_color_t nxt_color =
		level_ff[zone_pkg::LVL_INNER] ? zone_pkg::COLOR_RED :
		level_ff[zone_pkg::LVL_MIDDLE] ? zone_pkg::COLOR_YELLOW : zone_pkg::COLOR_GREEN;
	zone_pkg::led_color_t color_ff;
	logic power_ff;

	always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			color_ff <= zone_pkg::COLOR_GREEN;
			power_ff <= 1'b1;
		end else begin
			color_ff <= nxt_color;
			power_ff <= 1'b1;
		end
	end

	// run lamp steady while clear, blinking at the selected rate otherwise
	blink_gen run_blink (
		.clk_in(CLK_IN),
		.rst_n_in(RESET_N_IN),
		.run_in(obstacle),
		.half_cycles_in(half_sel),
		.blink_out(RUN_LED_OUT)
	);

	// ****************************************
	// outputs
	// ****************************************
	assign POINT_READY_OUT = point_ready_ff;
	assign TX_REC_OUT = tx_rec_ff;
	assign TX_VALID_OUT = tx_valid_ff;
	assign DETECT_OUT = detect;
	assign GROUP_OUT = group_ff;
	assign LEVEL_OUT = level_ff;
	assign STATUS_CODE_OUT = status_ff;
	assign POWER_LED_OUT = power_ff;
	assign RUN_COLOR_OUT = color_ff;

	// ****************************************
	// checks
	// ****************************************
	chk_init_exit_time: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		$rose(detect) |-> $past(init_cnt_ff) == INIT_CYCLES - 1)
		else $error("detection entered at the wrong time");
	chk_status_normal: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		detect && !FAULT_IN |=> status_ff == zone_pkg::NORMAL_STATUS_CODE)
		else $error("normal code missing while running cleanly");
	chk_upload_stops: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		!UPLOAD_EN_IN && tx_free |=> !tx_valid_ff)
		else $error("record offered while upload disabled");
	chk_auto_stream: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		streaming && zone_pend_ff && tx_free |=> tx_valid_ff && tx_rec_ff.kind == zone_pkg::REC_ZONE)
		else $error("pending zone result not sent");
	chk_group_follow: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		sw_settled |=> group_ff == $past(sw_s3_ff))
		else $error("group did not follow settled switches");
	chk_level_select: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		take_zone |=> level_ff == $past(grp_hits[group_ff]))
		else $error("level outputs not from selected group");
	chk_power_lit: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		power_ff)
		else $error("power lamp dark");
	chk_inner_red: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		level_ff[zone_pkg::LVL_INNER] |=> color_ff == zone_pkg::COLOR_RED)
		else $error("inner level not shown red");
	chk_inner_priority: assert property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		level_ff[zone_pkg::LVL_INNER] |=> run_blink.cnt_ff < FAST_HALF)
		else $error("inner level did not take the fast blink");
	cov_enter_detect: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN) $rose(detect));
	cov_zone_then_status: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		load_zone ##[1:8] load_status);
	cov_group_change: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN) $changed(group_ff));
	cov_upload_off: cover property (@(posedge CLK_IN) disable iff (!RESET_N_IN)
		detect && $fell(UPLOAD_EN_IN));

endmodule

`default_nettype wire

// ===== verif/host_model.sv
// host side of the record stream: takes records promptly or with random stalls
// assumes the record stream runs on the device clock; slow_in picks the pace
`timescale 1ns/10ps
`default_nettype none

module host_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic valid_in,
	input wire logic slow_in,
	output logic ready_out
);
	// ****************************************
	// ready pacing
	// ****************************************
	// stalls about one offered record in four when slow, so held records are exercised;
	// the draw sits in the clocked process so a fresh value is taken every cycle
	// ready updates just after the edge; host stays willing while upload is off
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ready_out <= 1'b0;
		end else begin
			ready_out <= !slow_in || !valid_in || (($urandom % 4) != 0);
		end
	end
endmodule
`default_nettype wire

// ===== verif/test_obstacle_zone_status_logic.sv
// self-checking bench of the obstacle zone status logic
// assumes shortened init and blink counts through the top module's parameters
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module test_obstacle_zone_status_logic;
	// ****************************************
	// signals
	// ****************************************
	localparam int INIT_N = 20; // shortened start-up phase
	localparam int FAST_N = 4; // shortened half periods
	localparam int MID_N = 8;
	localparam int SLOW_N = 16;
	logic clk_in = 1'b0; // 100 MHz clock
	logic rst_n = 1'b0; // active low reset
	logic [3:0] sw = 4'h0; // group switches
	logic [47:0] hits = 48'h0; // zone hits of all groups
	logic zvalid = 1'b0, pvalid = 1'b0, upload = 1'b1, fault = 1'b0, multi = 1'b0;
	logic slow = 1'b1; // host pace
	logic [31:0] point = 32'h0;
	logic [7:0] fcode = 8'h00;
	zone_pkg::tx_rec_t rec;
	zone_pkg::led_color_t color;
	logic pready, txv, txr, detect, pwr, run;
	logic [3:0] group;
	logic [2:0] level;
	logic [7:0] status;
	int fails = 0, check_count = 0, cycles = 0, n, h;
	logic [2:0] lv_pick; // random level set of one zone result
	logic [2:0] lv_tab [6] = '{3'b000, 3'b001, 3'b010, 3'b100, 3'b101, 3'b010};

	always #5 clk_in = ~clk_in;

	obstacle_zone_status_logic #(.INIT_CYCLES(INIT_N), .FAST_HALF(FAST_N),
		.MID_HALF(MID_N), .SLOW_HALF(SLOW_N)) uut (
		.CLK_IN(clk_in), .RESET_N_IN(rst_n), .SWITCH_IN(sw), .ZONE_HIT_IN(hits),
		.ZONE_VALID_IN(zvalid), .POINT_IN(point), .POINT_VALID_IN(pvalid),
		.POINT_READY_OUT(pready), .UPLOAD_EN_IN(upload), .FAULT_IN(fault),
		.FAULT_CODE_IN(fcode), .MULTICOLOR_IN(multi), .TX_REC_OUT(rec),
		.TX_VALID_OUT(txv), .TX_READY_IN(txr), .DETECT_OUT(detect), .GROUP_OUT(group),
		.LEVEL_OUT(level), .STATUS_CODE_OUT(status), .POWER_LED_OUT(pwr),
		.RUN_LED_OUT(run), .RUN_COLOR_OUT(color));

	host_model host (.clk_in(clk_in), .rst_n_in(rst_n), .valid_in(txv),
		.slow_in(slow), .ready_out(txr));

	// ****************************************
	// expectations
	// ****************************************
	// lamp half period: innermost level wins, colour variant always fast
	function automatic int exp_half(input logic [2:0] lv, input logic mc);
		if (lv == 3'b000) return 0;
		if (mc || lv[2]) return FAST_N;
		return lv[1] ? MID_N : SLOW_N;
	endfunction
	function automatic zone_pkg::led_color_t exp_color(input logic [2:0] lv);
		if (lv[2]) return zone_pkg::COLOR_RED;
		return lv[1] ? zone_pkg::COLOR_YELLOW : zone_pkg::COLOR_GREEN;
	endfunction

	// ****************************************
	// tasks
	// ****************************************
	// closing report; also reached by the cycle ceiling
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// waits for a handed-over record of one kind; other kinds pass by
	task automatic wait_rec(input zone_pkg::rec_kind_t k, input logic [31:0] exp);
		int i;
		for (i = 0; i < 200; i++) begin
			@(posedge clk_in);
			if (txv && txr && rec.kind === k) break;
		end
		`CHK(i < 200, 1'b1)
		`CHK(rec.payload, exp)
	endtask
	// one zone evaluation with the given levels on the active group
	// other groups carry random hits, so only the selected slice may show
	task automatic do_zone(input logic [2:0] lv);
		logic [47:0] hit_word;
		hit_word = 48'({$urandom, $urandom});
		hit_word[sw*3 +: 3] = lv;
		@(posedge clk_in);
		hits <= hit_word;
		zvalid <= 1'b1;
		@(posedge clk_in);
		zvalid <= 1'b0;
		@(posedge clk_in);
		#1;
		`CHK(level, lv)
	endtask
	// counts cycles between two lamp toggles; 0 when the lamp stands still
	task automatic measure(output int hp);
		logic prev;
		int k;
		hp = 0;
		prev = run;
		for (k = 0; k < 40 && run === prev; k++) begin @(posedge clk_in); #1; end
		if (k < 40) begin
			prev = run;
			for (k = 0; k < 40 && run === prev; k++) begin @(posedge clk_in); #1; end
			hp = k;
		end
	endtask
	// offers one point and holds it until the edge that takes it
	task automatic send_point(input logic [31:0] w);
		int i;
		@(posedge clk_in);
		pvalid <= 1'b1;
		point <= w;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_in);
			if (pready) break;
		end
		`CHK(i < 20, 1'b1)
		pvalid <= 1'b0;
	endtask

	// cycle ceiling well above the expected run length
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			$display("[ERR] %0t run took too long", $time);
			end_sim();
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(52187));
		repeat (16) @(posedge clk_in);
		#1;
		`CHK(pwr, 1'b1)
		`CHK(run, 1'b1)
		`CHK(status, zone_pkg::INIT_STATUS_CODE)
		// release on an edge with a zone result offered at once; start-up ignores it
		@(posedge clk_in);
		rst_n <= 1'b1;
		hits <= 48'hffff_ffff_ffff;
		zvalid <= 1'b1;
		@(posedge clk_in);
		zvalid <= 1'b0;
		#1;
		`CHK(level, 3'b000)
		// detection starts a fixed count of edges after release
		for (n = 1; n < 100 && !detect; n++) begin @(posedge clk_in); #1; end
		`CHK(n, INIT_N)
		`CHK(level, 3'b000)
		`CHK(txv, 1'b0)
		// the status register follows detection one cycle later
		@(posedge clk_in);
		#1;
		`CHK(status, zone_pkg::NORMAL_STATUS_CODE)
		// group switching with random groups and levels, slow host
		for (int j = 0; j < 4; j++) begin
			@(posedge clk_in);
			sw <= (j == 0) ? 4'hf : 4'($urandom);
			repeat (6) @(posedge clk_in);
			#1;
			`CHK(group, sw)
			lv_pick = 3'($urandom);
			do_zone(lv_pick);
			wait_rec(zone_pkg::REC_ZONE, {21'h0, sw, 4'h0, lv_pick});
			wait_rec(zone_pkg::REC_STATUS, {24'h0, zone_pkg::NORMAL_STATUS_CODE});
		end
		// fault code replaces the normal code in status and its record
		fault <= 1'b1;
		fcode <= 8'($urandom) | 8'h80;
		do_zone(3'b001);
		`CHK(status, fcode)
		wait_rec(zone_pkg::REC_STATUS, {24'h0, fcode});
		fault <= 1'b0;
		send_point(32'hdead_beef);
		wait_rec(zone_pkg::REC_POINT, 32'hdead_beef);
		// lamp patterns for clear, each single level and outer with inner, single and colour variants
		for (int j = 0; j < 6; j++) begin
			@(posedge clk_in);
			multi <= (j == 5);
			do_zone(lv_tab[j]);
			repeat (3) @(posedge clk_in);
			#1;
			`CHK(color, exp_color(lv_tab[j]))
			`CHK(pwr, 1'b1)
			measure(h);
			`CHK(h, exp_half(lv_tab[j], multi))
		end
		// upload off: nothing more is handed over, points are still taken
		@(posedge clk_in);
		slow <= 1'b0;
		upload <= 1'b0;
		repeat (6) @(posedge clk_in);
		send_point(32'($urandom));
		do_zone(3'b100);
		for (int j = 0; j < 20; j++) begin @(posedge clk_in); #1; `CHK(txv, 1'b0) end
		`CHK(pready, 1'b1)
		@(posedge clk_in);
		upload <= 1'b1;
		send_point(32'h0000_0001);
		wait_rec(zone_pkg::REC_POINT, 32'h0000_0001);
		end_sim();
	end
endmodule
`default_nettype wire
